// ==== verilog/flow_ctrl_defs.vh ====
/*
  Constants for the program-flow control block: opcodes of the flow
  operations, condition field layout and code points, stack geometry.
  Assumes it is included by bare name from the design and bench files.
*/
`ifndef FLOW_CTRL_DEFS_VH
`define FLOW_CTRL_DEFS_VH

`define STK_DEPTH 8
`define STK_PTR_W 4
`define PC_W 16
`define ACC_W 32
`define DATA_W 16

// Operation codes presented with OP_VALID_I
`define OP_W 4
`define OP_NONE 4'h0
`define OP_CALL 4'h1
`define OP_INTR 4'h2
`define OP_RET 4'h3
`define OP_PUSH_ACC 4'h4
`define OP_POP_ACC 4'h5
`define OP_PUSH_DMEM 4'h6
`define OP_POP_DMEM 4'h7
`define OP_BRANCH_ACC 4'h8
`define OP_COND_BRANCH 4'h9
`define OP_COND_BRANCH_DLY 4'hA
`define OP_COND_CALL 4'hB
`define OP_COND_CALL_DLY 4'hC
`define OP_COND_RET 4'hD
`define OP_COND_RET_DLY 4'hE
`define OP_COND_EXEC 4'hF

// Condition select: group fields packed into one word
`define CND_W 10
`define CND_G1_LSB 0
`define CND_G1_W 3
`define CND_G2_LSB 3
`define CND_G3_LSB 5
`define CND_G4_LSB 7
`define CND_G4_W 3
`define CND_G2_W 2
`define CND_G3_W 2

// Group 1: accumulator compare
`define G1_NONE 3'h0
`define G1_ZERO 3'h1
`define G1_NONZERO 3'h2
`define G1_NEG 3'h3
`define G1_NOTPOS 3'h4
`define G1_POS 3'h5
`define G1_NOTNEG 3'h6
// Group 2: overflow, group 3: carry
`define G2_NONE 2'h0
`define G2_NOOVF 2'h1
`define G2_OVF 2'h2
`define G3_NONE 2'h0
`define G3_NOCARRY 2'h1
`define G3_CARRY 2'h2
// Group 4: test flag or branch pin, one at most
`define G4_NONE 3'h0
`define G4_TC_CLR 3'h1
`define G4_TC_SET 3'h2
`define G4_PIN_LOW 3'h3

`endif

// ==== verilog/cond_eval.v ====
/*
  Combinational condition evaluator: every selected group must hold.
  Assumes all inputs come from logic on the core clock.
*/
`timescale 1ns/1ps
`include "flow_ctrl_defs.vh"

module cond_eval (
  input wire [`ACC_W-1:0] acc_i,
  input wire ovf_i,
  input wire carry_i,
  input wire tc_i,
  input wire pin_low_i,
  input wire [`CND_W-1:0] cnd_i,
  output reg pass_o,
  output reg bad_o
);
  wire [`CND_G1_W-1:0] g1 = cnd_i[`CND_G1_LSB +: `CND_G1_W];
  wire [`CND_G2_W-1:0] g2 = cnd_i[`CND_G2_LSB +: `CND_G2_W];
  wire [`CND_G3_W-1:0] g3 = cnd_i[`CND_G3_LSB +: `CND_G3_W];
  wire [`CND_G4_W-1:0] g4 = cnd_i[`CND_G4_LSB +: `CND_G4_W];
  wire is_zero = (acc_i == {`ACC_W{1'b0}});
  wire is_neg = acc_i[`ACC_W-1];
  reg c1;
  reg c2;
  reg c3;
  reg c4;

  always @* begin
    bad_o = 1'b0;
    case (g1)
      `G1_NONE: c1 = 1'b1;
      `G1_ZERO: c1 = is_zero;
      `G1_NONZERO: c1 = !is_zero;
      `G1_NEG: c1 = is_neg;
      `G1_NOTPOS: c1 = is_neg | is_zero;
      `G1_POS: c1 = !is_neg & !is_zero;
      `G1_NOTNEG: c1 = !is_neg;
      default: begin
        c1 = 1'b0;
        bad_o = 1'b1;
      end
    endcase
    case (g2)
      `G2_NONE: c2 = 1'b1;
      `G2_NOOVF: c2 = !ovf_i;
      `G2_OVF: c2 = ovf_i;
      default: begin
        c2 = 1'b0;
        bad_o = 1'b1;
      end
    endcase
    case (g3)
      `G3_NONE: c3 = 1'b1;
      `G3_NOCARRY: c3 = !carry_i;
      `G3_CARRY: c3 = carry_i;
      default: begin
        c3 = 1'b0;
        bad_o = 1'b1;
      end
    endcase
    // One field for flag or pin makes them mutually exclusive by encoding
    case (g4)
      `G4_NONE: c4 = 1'b1;
      `G4_TC_CLR: c4 = !tc_i;
      `G4_TC_SET: c4 = tc_i;
      `G4_PIN_LOW: c4 = pin_low_i;
      default: begin
        c4 = 1'b0;
        bad_o = 1'b1;
      end
    endcase
    pass_o = c1 & c2 & c3 & c4;
  end
endmodule // cond_eval

// ==== verilog/flow_ctrl.v ====
/*
  Program-flow control: eight-entry return stack, accumulator and data
  memory access to it, conditional transfers with delayed forms.
  Assumes the decoder presents one operation per OP_VALID_I pulse on CLK_I,
  flags come from core logic on CLK_I, and the branch pin is asynchronous.
*/
`timescale 1ns/1ps
`include "flow_ctrl_defs.vh"

module flow_ctrl (
  input wire CLK_I,
  input wire SYS_RST_I,
  input wire OP_VALID_I,
  input wire [`OP_W-1:0] OP_CODE_I,
  input wire [`CND_W-1:0] COND_SEL_I,
  input wire [`PC_W-1:0] TARGET_I,
  input wire [`PC_W-1:0] RET_PC_I,
  input wire [`ACC_W-1:0] ACC_I,
  input wire [`DATA_W-1:0] DMEM_RDATA_I,
  input wire OVF_I,
  input wire CARRY_I,
  input wire TC_I,
  input wire BRANCH_PIN_N_I,
  output wire PC_LOAD_O,
  output wire [`PC_W-1:0] PC_NEXT_O,
  output wire FLUSH_O,
  output wire EXEC_SKIP_O,
  output wire ACC_LOAD_O,
  output wire [`ACC_W-1:0] ACC_DATA_O,
  output wire DMEM_WE_O,
  output wire [`DATA_W-1:0] DMEM_WDATA_O,
  output wire COND_TRUE_O,
  output wire COND_BAD_O,
  output wire STK_OVF_O,
  output wire STK_UNF_O,
  output wire [`STK_PTR_W-1:0] STK_LEVEL_O
);
  reg [`PC_W-1:0] stk_ff [0:`STK_DEPTH-1];
  reg [`PC_W-1:0] nxt_stk [0:`STK_DEPTH-1];
  reg [`STK_PTR_W-1:0] level_ff;
  reg [`STK_PTR_W-1:0] nxt_level;
  reg pin_meta_ff;
  reg pin_low_ff;
  reg pc_load_ff;
  reg [`PC_W-1:0] pc_next_ff;
  reg flush_ff;
  reg skip_ff;
  reg acc_load_ff;
  reg [`ACC_W-1:0] acc_data_ff;
  reg dmem_we_ff;
  reg [`DATA_W-1:0] dmem_wdata_ff;
  reg cond_true_ff;
  reg cond_bad_ff;
  reg ovf_ff;
  reg unf_ff;
  reg nxt_pc_load;
  reg [`PC_W-1:0] nxt_pc_next;
  reg nxt_flush;
  reg nxt_skip;
  reg nxt_acc_load;
  reg [`ACC_W-1:0] nxt_acc_data;
  reg nxt_dmem_we;
  reg [`DATA_W-1:0] nxt_dmem_wdata;
  reg nxt_cond_true;
  reg nxt_cond_bad;
  reg nxt_ovf;
  reg nxt_unf;
  reg do_push;
  reg do_pop;
  reg [`PC_W-1:0] push_val;
  wire cond_pass;
  wire cond_bad;
  wire [`PC_W-1:0] top = stk_ff[0];
  integer k;

  function is_cond_op;
    input [`OP_W-1:0] op;
    begin
      is_cond_op = (op >= `OP_COND_BRANCH);
    end
  endfunction

  function is_delayed_op;
    input [`OP_W-1:0] op;
    begin
      is_delayed_op = (op == `OP_COND_BRANCH_DLY) || (op == `OP_COND_CALL_DLY) ||
                      (op == `OP_COND_RET_DLY);
    end
  endfunction

  // Branch pin is asynchronous: two flops before the evaluator sees it
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pin_meta_ff <= 1'b0;
      pin_low_ff <= 1'b0;
    end else begin
      pin_meta_ff <= !BRANCH_PIN_N_I;
      pin_low_ff <= pin_meta_ff;
    end
  end

  cond_eval u_cond (
    .acc_i(ACC_I),
    .ovf_i(OVF_I),
    .carry_i(CARRY_I),
    .tc_i(TC_I),
    .pin_low_i(pin_low_ff),
    .cnd_i(COND_SEL_I),
    .pass_o(cond_pass),
    .bad_o(cond_bad)
  );

  always @* begin
    do_push = 1'b0;
    do_pop = 1'b0;
    push_val = RET_PC_I;
    nxt_pc_load = 1'b0;
    nxt_pc_next = pc_next_ff;
    nxt_flush = 1'b0;
    nxt_skip = 1'b0;
    nxt_acc_load = 1'b0;
    nxt_acc_data = acc_data_ff;
    nxt_dmem_we = 1'b0;
    nxt_dmem_wdata = dmem_wdata_ff;
    nxt_cond_true = cond_true_ff;
    nxt_cond_bad = cond_bad_ff;
    if (OP_VALID_I) begin
      if (is_cond_op(OP_CODE_I)) begin
        nxt_cond_true = cond_pass & !cond_bad;
        nxt_cond_bad = cond_bad;
      end
      case (OP_CODE_I)
        `OP_CALL, `OP_INTR: begin
          do_push = 1'b1;
          nxt_pc_load = 1'b1;
          nxt_pc_next = TARGET_I;
          nxt_flush = 1'b1;
        end
        `OP_RET: begin
          do_pop = 1'b1;
          nxt_pc_load = 1'b1;
          nxt_pc_next = top;
          nxt_flush = 1'b1;
        end
        `OP_PUSH_ACC: begin
          do_push = 1'b1;
          push_val = ACC_I[`PC_W-1:0];
        end
        `OP_POP_ACC: begin
          do_pop = 1'b1;
          nxt_acc_load = 1'b1;
          nxt_acc_data = {{(`ACC_W-`PC_W){1'b0}}, top};
        end
        `OP_PUSH_DMEM: begin
          do_push = 1'b1;
          push_val = DMEM_RDATA_I;
        end
        `OP_POP_DMEM: begin
          do_pop = 1'b1;
          nxt_dmem_we = 1'b1;
          nxt_dmem_wdata = top;
        end
        `OP_BRANCH_ACC: begin
          nxt_pc_load = 1'b1;
          nxt_pc_next = ACC_I[`PC_W-1:0];
          nxt_flush = 1'b1;
        end
        `OP_COND_BRANCH, `OP_COND_BRANCH_DLY: begin
          if (cond_pass && !cond_bad) begin
            nxt_pc_load = 1'b1;
            nxt_pc_next = TARGET_I;
            // Delayed form keeps the following words in the pipe
            nxt_flush = !is_delayed_op(OP_CODE_I);
          end
        end
        `OP_COND_CALL, `OP_COND_CALL_DLY: begin
          if (cond_pass && !cond_bad) begin
            do_push = 1'b1;
            nxt_pc_load = 1'b1;
            nxt_pc_next = TARGET_I;
            nxt_flush = !is_delayed_op(OP_CODE_I);
          end
        end
        `OP_COND_RET, `OP_COND_RET_DLY: begin
          if (cond_pass && !cond_bad) begin
            do_pop = 1'b1;
            nxt_pc_load = 1'b1;
            nxt_pc_next = top;
            nxt_flush = !is_delayed_op(OP_CODE_I);
          end
        end
        `OP_COND_EXEC: begin
          nxt_skip = !(cond_pass && !cond_bad);
        end
        default: begin
          nxt_pc_load = 1'b0;
        end
      endcase
    end
  end

  // Full stack on push drops the oldest entry; empty pop returns the stale
  // bottom word. Both raise sticky flags so software can detect misuse.
  always @* begin
    nxt_level = level_ff;
    nxt_ovf = ovf_ff;
    nxt_unf = unf_ff;
    for (k = 0; k < `STK_DEPTH; k = k + 1) begin
      nxt_stk[k] = stk_ff[k];
    end
    if (do_push) begin
      for (k = `STK_DEPTH-1; k > 0; k = k - 1) begin
        nxt_stk[k] = stk_ff[k-1];
      end
      nxt_stk[0] = push_val;
      if (level_ff == `STK_DEPTH) begin
        nxt_ovf = 1'b1;
      end else begin
        nxt_level = level_ff + 4'h1;
      end
    end else if (do_pop) begin
      for (k = 0; k < `STK_DEPTH-1; k = k + 1) begin
        nxt_stk[k] = stk_ff[k+1];
      end
      if (level_ff == 4'h0) begin
        nxt_unf = 1'b1;
      end else begin
        nxt_level = level_ff - 4'h1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `STK_DEPTH; g = g + 1) begin : g_stk
      always @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
          stk_ff[g] <= 16'h0000;
        end else begin
          stk_ff[g] <= nxt_stk[g];
        end
      end
    end
  endgenerate

  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      level_ff <= 4'h0;
      ovf_ff <= 1'b0;
      unf_ff <= 1'b0;
      pc_load_ff <= 1'b0;
      pc_next_ff <= 16'h0000;
      flush_ff <= 1'b0;
      skip_ff <= 1'b0;
      acc_load_ff <= 1'b0;
      acc_data_ff <= 32'h00000000;
      dmem_we_ff <= 1'b0;
      dmem_wdata_ff <= 16'h0000;
      cond_true_ff <= 1'b0;
      cond_bad_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level;
      ovf_ff <= nxt_ovf;
      unf_ff <= nxt_unf;
      pc_load_ff <= nxt_pc_load;
      pc_next_ff <= nxt_pc_next;
      flush_ff <= nxt_flush;
      skip_ff <= nxt_skip;
      acc_load_ff <= nxt_acc_load;
      acc_data_ff <= nxt_acc_data;
      dmem_we_ff <= nxt_dmem_we;
      dmem_wdata_ff <= nxt_dmem_wdata;
      cond_true_ff <= nxt_cond_true;
      cond_bad_ff <= nxt_cond_bad;
    end
  end

  assign PC_LOAD_O = pc_load_ff;
  assign PC_NEXT_O = pc_next_ff;
  assign FLUSH_O = flush_ff;
  assign EXEC_SKIP_O = skip_ff;
  assign ACC_LOAD_O = acc_load_ff;
  assign ACC_DATA_O = acc_data_ff;
  assign DMEM_WE_O = dmem_we_ff;
  assign DMEM_WDATA_O = dmem_wdata_ff;
  assign COND_TRUE_O = cond_true_ff;
  assign COND_BAD_O = cond_bad_ff;
  assign STK_OVF_O = ovf_ff;
  assign STK_UNF_O = unf_ff;
  assign STK_LEVEL_O = level_ff;
endmodule // flow_ctrl

// ==== dv/flow_ctrl_sva.sv ====
/* Concurrent checks on the flow_ctrl top ports.
   Assumes the defs header is on the include path and the bind below. */
`timescale 1ns/1ps
`include "flow_ctrl_defs.vh"
module flow_ctrl_chk (
  input wire CLK_I,
  input wire SYS_RST_I,
  input wire OP_VALID_I,
  input wire [`OP_W-1:0] OP_CODE_I,
  input wire [`CND_W-1:0] COND_SEL_I,
  input wire [`PC_W-1:0] TARGET_I,
  input wire [`ACC_W-1:0] ACC_I,
  input wire PC_LOAD_O,
  input wire [`PC_W-1:0] PC_NEXT_O,
  input wire FLUSH_O,
  input wire DMEM_WE_O,
  input wire COND_TRUE_O,
  input wire COND_BAD_O,
  input wire STK_OVF_O,
  input wire [`STK_PTR_W-1:0] STK_LEVEL_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  wire cb = OP_VALID_I && OP_CODE_I == `OP_COND_BRANCH;
  wire op_ok = OP_VALID_I;
  a_call_target: assert property (op_ok && OP_CODE_I == `OP_CALL |=> PC_LOAD_O && FLUSH_O && PC_NEXT_O == $past(TARGET_I))
    else $error("call did not load target");
  a_delay_noflush: assert property (op_ok && OP_CODE_I == `OP_COND_BRANCH_DLY |=> !FLUSH_O)
    else $error("delayed branch flushed");
  a_zero_test: assert property (cb && COND_SEL_I == 10'h001 |=> COND_TRUE_O == ($past(ACC_I) == 32'h0))
    else $error("zero test wrong");
  a_neg_test: assert property (cb && COND_SEL_I == 10'h003 |=> COND_TRUE_O == $past(ACC_I[31]))
    else $error("negative test wrong");
  a_pos_test: assert property (cb && COND_SEL_I == 10'h005 |=> COND_TRUE_O == ($past(ACC_I) != 0 && !$past(ACC_I[31])))
    else $error("positive test wrong");
  a_bad_group: assert property (cb && COND_SEL_I[9:7] > 3'h3 |=> COND_BAD_O && !COND_TRUE_O)
    else $error("illegal group accepted");
  a_push_level: assert property (op_ok && OP_CODE_I == `OP_PUSH_DMEM && STK_LEVEL_O < 4'h8 |=> STK_LEVEL_O == $past(STK_LEVEL_O) + 4'h1)
    else $error("push did not raise level");
  a_level_bound: assert property (STK_LEVEL_O <= 4'h8)
    else $error("level above depth");
  a_pop_write: assert property (op_ok && OP_CODE_I == `OP_POP_DMEM |=> DMEM_WE_O)
    else $error("pop to memory without write");
  a_ovf_sticky: assert property (STK_OVF_O |=> STK_OVF_O)
    else $error("overflow flag dropped");
endmodule // flow_ctrl_chk

bind flow_ctrl flow_ctrl_chk chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .OP_VALID_I(OP_VALID_I),
  .OP_CODE_I(OP_CODE_I), .COND_SEL_I(COND_SEL_I), .TARGET_I(TARGET_I), .ACC_I(ACC_I),
  .PC_LOAD_O(PC_LOAD_O), .PC_NEXT_O(PC_NEXT_O), .FLUSH_O(FLUSH_O), .DMEM_WE_O(DMEM_WE_O),
  .COND_TRUE_O(COND_TRUE_O), .COND_BAD_O(COND_BAD_O), .STK_OVF_O(STK_OVF_O), .STK_LEVEL_O(STK_LEVEL_O));

// ==== dv/test_flow_ctrl.sv ====
/* Self-checking bench for flow_ctrl: stack, transfers, conditions.
   Assumes the design, its defs header and the checker compile alongside. */
`timescale 1ns/1ps
`include "flow_ctrl_defs.vh"
module test_flow_ctrl;
  reg CLK_I = 1'b0;
  reg SYS_RST_I = 1'b1;
  reg OP_VALID_I = 1'b0;
  reg [`OP_W-1:0] OP_CODE_I = `OP_NONE;
  reg [`CND_W-1:0] COND_SEL_I = 10'h000;
  reg [`PC_W-1:0] TARGET_I = 16'h0000;
  reg [`PC_W-1:0] RET_PC_I = 16'h0000;
  reg [`ACC_W-1:0] ACC_I = 32'h00000000;
  reg [`DATA_W-1:0] DMEM_RDATA_I = 16'h0000;
  reg OVF_I = 1'b0;
  reg CARRY_I = 1'b0;
  reg TC_I = 1'b0;
  reg BRANCH_PIN_N_I = 1'b1;
  wire PC_LOAD_O, FLUSH_O, EXEC_SKIP_O, ACC_LOAD_O, DMEM_WE_O, COND_TRUE_O, COND_BAD_O, STK_OVF_O, STK_UNF_O;
  wire [`PC_W-1:0] PC_NEXT_O;
  wire [`ACC_W-1:0] ACC_DATA_O;
  wire [`DATA_W-1:0] DMEM_WDATA_O;
  wire [`STK_PTR_W-1:0] STK_LEVEL_O;
  int err_total = 0;
  int num_checks = 0;

  flow_ctrl DUT (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .OP_VALID_I(OP_VALID_I), .OP_CODE_I(OP_CODE_I),
    .COND_SEL_I(COND_SEL_I), .TARGET_I(TARGET_I), .RET_PC_I(RET_PC_I), .ACC_I(ACC_I),
    .DMEM_RDATA_I(DMEM_RDATA_I), .OVF_I(OVF_I), .CARRY_I(CARRY_I), .TC_I(TC_I),
    .BRANCH_PIN_N_I(BRANCH_PIN_N_I), .PC_LOAD_O(PC_LOAD_O), .PC_NEXT_O(PC_NEXT_O), .FLUSH_O(FLUSH_O),
    .EXEC_SKIP_O(EXEC_SKIP_O), .ACC_LOAD_O(ACC_LOAD_O), .ACC_DATA_O(ACC_DATA_O), .DMEM_WE_O(DMEM_WE_O),
    .DMEM_WDATA_O(DMEM_WDATA_O), .COND_TRUE_O(COND_TRUE_O), .COND_BAD_O(COND_BAD_O),
    .STK_OVF_O(STK_OVF_O), .STK_UNF_O(STK_UNF_O), .STK_LEVEL_O(STK_LEVEL_O));

  initial begin
    forever #50 CLK_I = ~CLK_I;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Reset also clears the sticky stack flags between scenarios
  task rst;
    SYS_RST_I = 1'b1;
    repeat (6) @(posedge CLK_I);
    #1;
    SYS_RST_I = 1'b0;
  endtask

  // One idle edge passes first, so valid is never lowered and raised in one time step.
  // Returns 1 ns after the taking edge, when outputs have landed
  task issue(input logic [3:0] c, input logic [9:0] s);
    @(posedge CLK_I);
    #1;
    OP_CODE_I = c;
    COND_SEL_I = s;
    OP_VALID_I = 1'b1;
    @(posedge CLK_I);
    #1;
    OP_VALID_I = 1'b0;
  endtask

  function logic g1(input logic [2:0] k, input logic [31:0] a);
    case (k)
      3'h1: g1 = a == 0;
      3'h2: g1 = a != 0;
      3'h3: g1 = a[31];
      3'h4: g1 = a[31] || a == 0;
      3'h5: g1 = !a[31] && a != 0;
      default: g1 = !a[31];
    endcase
  endfunction

  task t_call_ret;
    rst;
    TARGET_I = 16'h1234;
    RET_PC_I = 16'h0ABC;
    issue(`OP_CALL, 10'h000);
    chk({PC_LOAD_O, FLUSH_O, PC_NEXT_O, STK_LEVEL_O}, {2'h3, 16'h1234, 4'h1});
    issue(`OP_RET, 10'h000);
    chk({PC_LOAD_O, PC_NEXT_O, STK_LEVEL_O}, {1'h1, 16'h0ABC, 4'h0});
    RET_PC_I = 16'h5555;
    issue(`OP_INTR, 10'h000);
    chk({PC_LOAD_O, FLUSH_O, PC_NEXT_O, STK_LEVEL_O}, {2'h3, 16'h1234, 4'h1});
    issue(`OP_POP_ACC, 10'h000);
    chk(ACC_DATA_O, 32'h00005555);
    ACC_I = 32'hDEADBEEF;
    issue(`OP_PUSH_ACC, 10'h000);
    issue(`OP_POP_ACC, 10'h000);
    chk({ACC_LOAD_O, ACC_DATA_O[30:0]}, {1'h1, 31'h0000BEEF});
    chk(ACC_DATA_O, 32'h0000BEEF);
    ACC_I = 32'h00000123;
    issue(`OP_BRANCH_ACC, 10'h000);
    chk({PC_LOAD_O, PC_NEXT_O}, {1'h1, 16'h0123});
    $display("test call_ret done, mismatches %0d", err_total);
  endtask

  task t_lifo;
    int i;
    rst;
    for (i = 1; i <= 9; i++) begin
      DMEM_RDATA_I = i[15:0];
      issue(`OP_PUSH_DMEM, 10'h000);
      chk({STK_OVF_O, STK_LEVEL_O}, {i == 9, (i > 8) ? 4'h8 : i[3:0]});
    end
    // The ninth push dropped the oldest entry, so pops return 9 down to 2
    for (i = 9; i >= 2; i--) begin
      issue(`OP_POP_DMEM, 10'h000);
      chk({DMEM_WE_O, DMEM_WDATA_O}, {1'h1, i[15:0]});
    end
    chk({STK_UNF_O, STK_LEVEL_O}, 5'h00);
    issue(`OP_POP_DMEM, 10'h000);
    chk({STK_UNF_O, STK_OVF_O, STK_LEVEL_O}, 6'h30);
    $display("test lifo done, mismatches %0d", err_total);
  endtask

  task t_cond_ops;
    int c;
    logic t;
    logic [3:0] op;
    rst;
    TARGET_I = 16'h0F0F;
    RET_PC_I = 16'h5555;
    for (c = 0; c < 14; c++) begin
      op = 4'h9 + c[3:1];
      t = !c[0];
      ACC_I = c[0];
      issue(op, 10'h001);
      chk(COND_TRUE_O, t);
      chk({EXEC_SKIP_O, PC_LOAD_O}, {op == `OP_COND_EXEC && !t, op != `OP_COND_EXEC && t});
      chk(FLUSH_O, t && op[0] && op != `OP_COND_EXEC);
      // Conditional returns pop what the conditional calls pushed
      if (t && op != `OP_COND_EXEC) chk(PC_NEXT_O, (op >= `OP_COND_RET) ? 16'h5555 : 16'h0F0F);
    end
    $display("test cond_ops done, mismatches %0d", err_total);
  endtask

  task t_compare;
    logic [31:0] v [6];
    int j;
    int k;
    v = '{32'h00000000, 32'h00000001, 32'hFFFFFFFF, 32'h80000000, 32'h7FFFFFFF, 32'h00010000};
    for (j = 0; j < 6; j++) begin
      for (k = 1; k <= 6; k++) begin
        ACC_I = v[j];
        issue(`OP_COND_BRANCH, {7'h00, k[2:0]});
        chk(COND_TRUE_O, g1(k[2:0], v[j]));
      end
    end
    $display("test compare done, mismatches %0d", err_total);
  endtask

  task t_multi;
    int i;
    for (i = 0; i < 16; i++) begin
      OVF_I = i[0];
      CARRY_I = i[1];
      TC_I = i[2];
      ACC_I = i[3] ? 32'hFFFFFFFF : 32'h00000005;
      issue(`OP_COND_BRANCH, {3'h2, 2'h2, 2'h1, 3'h3});
      chk(COND_TRUE_O, i[3] && !i[0] && i[1] && i[2]);
    end
    issue(`OP_COND_BRANCH, {3'h4, 2'h2, 2'h1, 3'h3});
    chk({COND_BAD_O, COND_TRUE_O}, 2'h2);
    // Opposite polarity of the overflow, carry and flag groups
    for (i = 0; i < 8; i++) begin
      OVF_I = i[0];
      CARRY_I = i[1];
      TC_I = i[2];
      issue(`OP_COND_BRANCH, {3'h1, 2'h1, 2'h2, 3'h0});
      chk(COND_TRUE_O, i[0] && !i[1] && !i[2]);
    end
    issue(`OP_COND_BRANCH, 10'h007);
    chk({COND_BAD_O, COND_TRUE_O}, 2'h2);
    issue(`OP_COND_BRANCH, 10'h018);
    chk({COND_BAD_O, COND_TRUE_O}, 2'h2);
    issue(`OP_COND_BRANCH, 10'h060);
    chk({COND_BAD_O, COND_TRUE_O}, 2'h2);
    TC_I = 1'b0;
    for (i = 0; i < 2; i++) begin
      BRANCH_PIN_N_I = i[0];
      repeat (3) @(posedge CLK_I);
      #1;
      issue(`OP_COND_BRANCH, {3'h3, 7'h00});
      chk({COND_BAD_O, COND_TRUE_O}, {1'h0, !i[0]});
    end
    $display("test multi done, mismatches %0d", err_total);
  endtask

  // Stimulus repeats a three-word block three times: push, pop, conditional branch
  task t_loop;
    int n;
    ACC_I = 32'h00000042;
    TARGET_I = 16'h0200;
    for (n = 0; n < 3; n++) begin
      issue(`OP_PUSH_ACC, 10'h000);
      issue(`OP_POP_ACC, 10'h000);
      chk(ACC_DATA_O, 32'h00000042);
      issue(`OP_COND_BRANCH, 10'h002);
      chk({PC_LOAD_O, PC_NEXT_O}, {1'h1, 16'h0200});
    end
    $display("test loop done, mismatches %0d", err_total);
  endtask

  initial begin
    t_call_ret;
    t_lifo;
    t_cond_ops;
    t_compare;
    t_multi;
    t_loop;
    print_verdict;
  end

  // Watchdog well beyond the planned run length
  initial begin
    #5000000;
    err_total++;
    print_verdict;
  end
endmodule // test_flow_ctrl
